/* src/mde_pkg.sv */
// package: operation codes, widths and timing counts of the multiply/divide engine
package mde_pkg;
  localparam int unsigned DATA_W    = 32;
  localparam int unsigned HALF_W    = 16;
  localparam int unsigned OP_W      = 4;
  // operation codes presented on op_in
  localparam logic [3:0]  OP_MULT   = 4'h0;  // signed multiply
  localparam logic [3:0]  OP_MULTU  = 4'h1;  // unsigned multiply
  localparam logic [3:0]  OP_MADD   = 4'h2;  // signed accumulate add
  localparam logic [3:0]  OP_MADDU  = 4'h3;
  localparam logic [3:0]  OP_MSUB   = 4'h4;  // signed accumulate subtract
  localparam logic [3:0]  OP_MSUBU  = 4'h5;
  localparam logic [3:0]  OP_DIV    = 4'h6;
  localparam logic [3:0]  OP_DIVU   = 4'h7;
  localparam logic [3:0]  OP_MTLO   = 4'h8;  // load low half of accumulator
  localparam logic [3:0]  OP_MTHI   = 4'h9;  // load high half of accumulator
  // timing counts in clock cycles
  localparam int unsigned WIDE_MUL_CYC = 2;
  localparam int unsigned DIV_CYC      = 33;
  localparam logic [5:0]  DIV_CNT_LAST = 6'h20;  // count 0..32 spans 33 cycles
  // engine states
  typedef enum logic [2:0] {
    MDE_IDLE = 3'b001,
    MDE_WIDE = 3'b010,
    MDE_DIV  = 3'b100
  } mde_state_e;
endpackage

/* src/mde_acc_if.sv */
// interface: accumulator pair carried between engine and its hold register
`timescale 1ns/1ns
interface mde_acc_if;
  import mde_pkg::*;
  logic              wr_en;
  logic [DATA_W-1:0] wr_hi;
  logic [DATA_W-1:0] wr_lo;
  logic [DATA_W-1:0] rd_hi;
  logic [DATA_W-1:0] rd_lo;
  modport engine (output wr_en, wr_hi, wr_lo, input rd_hi, rd_lo);
  modport store  (input wr_en, wr_hi, wr_lo, output rd_hi, rd_lo);
endinterface

/* src/mde_acc_store.sv */
// accumulator hold register: high and low result words with registered read data
`timescale 1ns/1ns
module mde_acc_store
  import mde_pkg::*;
(
  // clock and reset
  input  wire logic clock_in,
  input  wire logic rst_in,
  // accumulator access
  mde_acc_if.store  acc
);
  logic [DATA_W-1:0] hi_ff;
  logic [DATA_W-1:0] lo_ff;

  // hold the pair; written only by the engine, on completion or on an OP_MTLO/OP_MTHI load
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      hi_ff <= 32'h0000_0000;
      lo_ff <= 32'h0000_0000;
    end else if (acc.wr_en) begin
      hi_ff <= acc.wr_hi;
      lo_ff <= acc.wr_lo;
    end
  end

  assign acc.rd_hi = hi_ff;
  assign acc.rd_lo = lo_ff;
endmodule

/* src/mde_engine.sv */
// multiply/divide engine running beside the core pipeline
// Contract
// - own pipeline advances independently of core
// - long operations stall the core only on its next issue, until busy_out falls
// - short multiplies accepted every single cycle
// - full wide multiply takes two cycles
// - divide delivers quotient, remainder in 34 cycles, busy for 33 of them
// - accumulate adds or subtracts product into result
`timescale 1ns/1ns
module mde_engine
  import mde_pkg::*;
(
  // clock and reset
  input  wire logic                  clock_in,
  input  wire logic                  rst_in,
  // issue from execute stage
  input  wire logic                  issue_in,
  input  wire logic [mde_pkg::OP_W-1:0]   op_in,
  input  wire logic [mde_pkg::DATA_W-1:0] src_a_in,
  input  wire logic [mde_pkg::DATA_W-1:0] src_b_in,
  // results to execute stage
  output logic                       busy_out,
  output logic                       done_out,
  output logic [mde_pkg::DATA_W-1:0] hi_out,
  output logic [mde_pkg::DATA_W-1:0] lo_out
);
  import mde_pkg::*;

  mde_acc_if acc ();
  mde_acc_store u_store (
    .clock_in (clock_in),
    .rst_in   (rst_in),
    .acc      (acc.store)
  );

  mde_state_e          state_ff;
  mde_state_e          nxt_state;
  logic [5:0]          cnt_ff;
  logic [OP_W-1:0]     op_ff;
  logic [63:0]         prod_ff;     // wide multiply partial sum
  logic [DATA_W-1:0]   b_ff;
  logic [DATA_W-1:0]   quo_ff;
  logic [DATA_W:0]     rem_ff;
  logic                neg_q_ff;
  logic                neg_r_ff;
  logic                done_ff;
  logic                busy_ff;
  logic [DATA_W-1:0]   hi_ff;
  logic [DATA_W-1:0]   lo_ff;
  logic [63:0]         lowpart_ff;  // low partial kept for the second wide cycle
  logic [63:0]         p_low_q;

  // operation classification
  function automatic logic is_signed(input logic [OP_W-1:0] op);
    is_signed = (op == OP_MULT) || (op == OP_MADD) || (op == OP_MSUB) || (op == OP_DIV);
  endfunction
  function automatic logic [DATA_W-1:0] mag(input logic [DATA_W-1:0] v, input logic s);
    mag = (s && v[DATA_W-1]) ? DATA_W'(-v) : v;
  endfunction
  function automatic logic [63:0] ext(input logic [DATA_W-1:0] v, input logic s);
    ext = {{DATA_W{s & v[DATA_W-1]}}, v};
  endfunction

  wire        op_sgn    = is_signed(op_in);
  wire        is_div    = (op_in == OP_DIV) || (op_in == OP_DIVU);
  wire        is_mul    = (op_in <= OP_MSUBU);
  wire        is_mt     = (op_in == OP_MTLO) || (op_in == OP_MTHI);
  // b fitting in 16 signed/unsigned bits makes a short multiply
  wire [16:0] b_top     = src_b_in[DATA_W-1:HALF_W-1];
  wire        b_short   = op_sgn ? ((b_top == 17'h00000) || (b_top == 17'h1FFFF))
                                 : (src_b_in[DATA_W-1:HALF_W] == 16'h0000);
  wire        idle      = (state_ff == MDE_IDLE);
  wire        take      = issue_in && idle;
  wire        wide_take = take && is_mul && !b_short;
  wire        div_take  = take && is_div;
  wire        fast_take = take && is_mul && b_short;

  // one-cycle short product and upper partial for the wide case
  wire [63:0] a_ext     = ext(src_a_in, op_sgn);
  wire [63:0] b_lo_ext  = {48'h0000_0000_0000, src_b_in[HALF_W-1:0]};
  wire [63:0] b_hi_ext  = ext(src_b_in, op_sgn) >> HALF_W;
  wire [63:0] p_low     = 64'(a_ext * b_lo_ext);
  wire [63:0] p_full    = 64'(a_ext * ext(src_b_in, op_sgn));
  wire [63:0] p_hi_part = 64'(64'(a_ext * b_hi_ext) << HALF_W);
  wire [63:0] acc_pair  = {acc.rd_hi, acc.rd_lo};

  // fold a product into the accumulator per the operation
  function automatic logic [63:0] fold(input logic [OP_W-1:0] op, input logic [63:0] p,
                                       input logic [63:0] a);
    if (op == OP_MADD || op == OP_MADDU) begin
      fold = 64'(a + p);
    end else if (op == OP_MSUB || op == OP_MSUBU) begin
      fold = 64'(a - p);
    end else begin
      fold = p;
    end
  endfunction

  // restoring divide step on remainder/quotient
  wire [DATA_W:0]   rem_sh  = {rem_ff[DATA_W-1:0], quo_ff[DATA_W-1]};
  wire [DATA_W:0]   rem_sub = 33'(rem_sh - {1'b0, b_ff});
  wire              sub_ok  = !rem_sub[DATA_W];
  wire [DATA_W-1:0] q_fin   = neg_q_ff ? DATA_W'(-quo_ff) : quo_ff;
  wire [DATA_W-1:0] r_fin   = neg_r_ff ? DATA_W'(-rem_ff[DATA_W-1:0])
                                       : rem_ff[DATA_W-1:0];
  wire              div_end = (state_ff == MDE_DIV) && (cnt_ff == DIV_CNT_LAST);
  wire              wide_end = (state_ff == MDE_WIDE);

  // next state: engine sequences on its own; core waits for it only to issue again
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      MDE_IDLE: begin
        if (wide_take) begin
          nxt_state = MDE_WIDE;
        end else if (div_take) begin
          nxt_state = MDE_DIV;
        end
      end
      MDE_WIDE: nxt_state = MDE_IDLE;
      MDE_DIV:  nxt_state = div_end ? MDE_IDLE : MDE_DIV;
      default:  nxt_state = MDE_IDLE;
    endcase
  end

  // accumulator write on any completion
  assign acc.wr_en = fast_take || wide_end || div_end || (take && is_mt);
  always_comb begin
    acc.wr_hi = acc.rd_hi;
    acc.wr_lo = acc.rd_lo;
    if (fast_take) begin
      // full product: a negative short b needs its sign, not just its low half
      {acc.wr_hi, acc.wr_lo} = fold(op_in, p_full, acc_pair);
    end else if (wide_end) begin
      {acc.wr_hi, acc.wr_lo} = fold(op_ff, 64'(prod_ff + p_low_q), acc_pair);
    end else if (div_end) begin
      acc.wr_hi = r_fin;
      acc.wr_lo = q_fin;
    end else if (take && op_in == OP_MTLO) begin
      acc.wr_lo = src_a_in;
    end else if (take && op_in == OP_MTHI) begin
      acc.wr_hi = src_a_in;
    end
  end

  // low partial of wide product held for the second cycle
  assign p_low_q = lowpart_ff;

  // state and operand capture; runs every cycle regardless of the core
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state_ff <= MDE_IDLE;
      cnt_ff   <= 6'h00;
      op_ff    <= 4'h0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= (state_ff == MDE_DIV) ? 6'(cnt_ff + 6'h01) : 6'h00;
      op_ff    <= take ? op_in : op_ff;
    end
  end

  // wide multiply halves and divide datapath
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      prod_ff    <= 64'h0;
      lowpart_ff <= 64'h0;
      b_ff       <= 32'h0;
      quo_ff     <= 32'h0;
      rem_ff     <= 33'h0;
      neg_q_ff   <= 1'b0;
      neg_r_ff   <= 1'b0;
    end else if (wide_take) begin
      prod_ff    <= p_hi_part;
      lowpart_ff <= p_low;
    end else if (div_take) begin
      b_ff     <= mag(src_b_in, op_sgn);
      quo_ff   <= mag(src_a_in, op_sgn);
      rem_ff   <= 33'h0;
      neg_q_ff <= op_sgn && (src_a_in[DATA_W-1] ^ src_b_in[DATA_W-1]);
      neg_r_ff <= op_sgn && src_a_in[DATA_W-1];
    end else if (state_ff == MDE_DIV && cnt_ff < DIV_CNT_LAST) begin
      // one quotient bit per cycle, last cycle applies signs
      rem_ff <= sub_ok ? rem_sub : rem_sh;
      quo_ff <= {quo_ff[DATA_W-2:0], sub_ok};
    end
  end

  // registered status toward the core
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      busy_ff <= (nxt_state != MDE_IDLE);
      done_ff <= acc.wr_en && !(take && is_mt);
    end
  end

  // results mirror the accumulator after it settles
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      hi_ff <= 32'h0;
      lo_ff <= 32'h0;
    end else begin
      hi_ff <= acc.wr_en ? acc.wr_hi : acc.rd_hi;
      lo_ff <= acc.wr_en ? acc.wr_lo : acc.rd_lo;
    end
  end

  assign busy_out = busy_ff;
  assign done_out = done_ff;
  assign hi_out   = hi_ff;
  assign lo_out   = lo_ff;

  // wide multiply raises busy for exactly one cycle after issue
  property p_wide_two;
    @(posedge clock_in) disable iff (rst_in)
      wide_take |=> busy_out ##1 (!busy_out && done_out);
  endproperty
  a_wide_two: assert property (p_wide_two) else $error("wide multiply not two cycles");

  // short multiply completes the very next cycle without busy
  property p_short_one;
    @(posedge clock_in) disable iff (rst_in)
      fast_take |=> (done_out && !busy_out);
  endproperty
  a_short_one: assert property (p_short_one) else $error("short multiply late");

  // divide completes after 33 cycles
  property p_div_len;
    @(posedge clock_in) disable iff (rst_in)
      div_take |=> busy_out [*8] ##1 busy_out [*8] ##1 busy_out [*8] ##1 busy_out [*8]
        ##1 busy_out ##1 (!busy_out && done_out);
  endproperty
  a_div_len: assert property (p_div_len) else $error("divide length wrong");

  // back-to-back short multiplies are all accepted: engine is free again next cycle
  property p_every_cycle;
    @(posedge clock_in) disable iff (rst_in)
      fast_take |=> (idle && !busy_out);
  endproperty
  a_every_cycle: assert property (p_every_cycle) else $error("idle but busy");

  // accumulate add lands in result
  property p_mac;
    @(posedge clock_in) disable iff (rst_in)
      (fast_take && op_in == OP_MADDU) |=>
        ({hi_out, lo_out} == 64'($past(acc_pair) + $past(p_low)));
  endproperty
  a_mac: assert property (p_mac) else $error("accumulate add wrong");

  // done never raised while engine still busy
  property p_busy_done;
    @(posedge clock_in) disable iff (rst_in)
      busy_out |-> !done_out;
  endproperty
  a_busy_done: assert property (p_busy_done) else $error("done during busy");

  // state advances on its own once started
  property p_advance;
    @(posedge clock_in) disable iff (rst_in)
      (state_ff == MDE_DIV && !div_end) |=> (cnt_ff == 6'($past(cnt_ff) + 6'h01));
  endproperty
  a_advance: assert property (p_advance) else $error("engine stalled");

  // issue refused while busy leaves accumulator untouched
  property p_refuse;
    @(posedge clock_in) disable iff (rst_in)
      (issue_in && !idle && !wide_end && !div_end) |-> !acc.wr_en;
  endproperty
  a_refuse: assert property (p_refuse) else $error("write while busy");
endmodule

/* bench/mde_core_model.sv */
// execute stage model: issues engine operations and keeps the busy interlock
`timescale 1ns/1ns
module mde_core_model (
  // clock and engine status
  input  wire logic                       clock_in,
  input  wire logic                       busy_in,
  // issue towards engine
  output logic                            issue_out,
  output logic [mde_pkg::OP_W-1:0]        op_out,
  output logic [mde_pkg::DATA_W-1:0]      src_a_out,
  output logic [mde_pkg::DATA_W-1:0]      src_b_out
);
  import mde_pkg::*;

  // idle lines at time zero
  initial begin
    issue_out = 1'b0;
    op_out    = 4'h0;
    src_a_out = 32'h0;
    src_b_out = 32'h0;
  end

  // raise one request at the falling edge; lock_off breaks the interlock on purpose
  task automatic send(input logic [3:0] op, input logic [31:0] a, b, input bit lock_off);
    @(negedge clock_in);
    while (busy_in !== 1'b0 && !lock_off) begin
      @(negedge clock_in);
    end
    issue_out = 1'b1;
    op_out    = op;
    src_a_out = a;
    src_b_out = b;
  endtask

  // release; lines flip so a stale operand is never mistaken for a held one
  task automatic quiet();
    @(negedge clock_in);
    issue_out = 1'b0;
    op_out    = ~op_out;
    src_a_out = ~src_a_out;
    src_b_out = ~src_b_out;
  endtask
endmodule

/* bench/tb_top.sv */
// testbench: engine driven through the execute stage model, self-checking
`timescale 1ns/1ns
module tb_top;
  import mde_pkg::*;
  logic        clock_in;
  logic        rst_in;
  logic        issue;
  logic        busy;
  logic        done;
  logic [3:0]  op;
  logic [31:0] src_a;
  logic [31:0] src_b;
  logic [31:0] hi;
  logic [31:0] lo;
  logic [63:0] acc;
  int          err_count;
  int          num_checks;

  mde_engine i_mde_engine (.clock_in(clock_in), .rst_in(rst_in), .issue_in(issue),
    .op_in(op), .src_a_in(src_a), .src_b_in(src_b), .busy_out(busy), .done_out(done),
    .hi_out(hi), .lo_out(lo));
  mde_core_model i_mde_core_model (.clock_in(clock_in), .busy_in(busy), .issue_out(issue),
    .op_out(op), .src_a_out(src_a), .src_b_out(src_b));

  // 100 MHz clock
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end

  // compare helpers
  task automatic bad(input logic [63:0] got, exp);
    err_count++;
    $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
  endtask
  task automatic chk_res(input logic [63:0] got, exp);
    num_checks++;
    if (got !== exp) bad(got, exp);
  endtask
  task automatic chk_flag(input logic got, exp);
    num_checks++;
    if (got !== exp) bad(64'(got), 64'(exp));
  endtask
  task automatic chk_cnt(input int got, exp);
    num_checks++;
    if (got != exp) bad(64'(got), 64'(exp));
  endtask

  // reference result, worked out from the operation and the held accumulator
  function automatic logic [63:0] expect_of(input logic [3:0] o, input logic [31:0] a, b);
    logic signed [63:0] ps;
    logic [63:0]        pu;
    ps = $signed(a) * $signed(b);
    pu = {32'h0, a} * {32'h0, b};
    case (o)
      OP_MULT:  return ps;
      OP_MULTU: return pu;
      OP_MADD:  return acc + ps;
      OP_MADDU: return acc + pu;
      OP_MSUB:  return acc - ps;
      OP_MSUBU: return acc - pu;
      OP_DIV:   return {32'($signed(a) % $signed(b)), 32'($signed(a) / $signed(b))};
      default:  return {a % b, a / b};
    endcase
  endfunction

  // one operation: edges to done, busy cycles, result; inj>=0 issues past the interlock
  task automatic run_op(input logic [3:0] o, input logic [31:0] a, b, input int lat, inj);
    int          n;
    int          nb;
    logic [63:0] e;
    e = expect_of(o, a, b);
    n = 0;
    nb = 0;
    i_mde_core_model.send(o, a, b, 1'b0);
    while (done !== 1'b1 && n < 100) begin
      if (n == inj) i_mde_core_model.send(OP_MULTU, 32'hFFFFFFFF, 32'h0000FFFF, 1'b1);
      else i_mde_core_model.quiet();
      n++;
      if (busy === 1'b1) nb++;
    end
    chk_cnt(n, lat);
    chk_cnt(nb, lat - 1);
    chk_res({hi, lo}, e);
    acc = e;
    i_mde_core_model.quiet();
    chk_flag(done, 1'b0);
  endtask

  task automatic t_short();
    logic [3:0]  ops[3] = '{OP_MULT, OP_MULTU, OP_MULT};
    logic [31:0] as[3]  = '{32'h80000001, 32'hFFFFFFFF, 32'h00001234};
    logic [31:0] bs[3]  = '{32'h00007FFF, 32'h0000FFFF, 32'hFFFFFFF0};
    // each new issue sees the result of the one before, one per cycle
    for (int i = 0; i < 3; i++) begin
      i_mde_core_model.send(ops[i], as[i], bs[i], 1'b0);
      if (i > 0) begin
        chk_flag(done, 1'b1);
        chk_res({hi, lo}, expect_of(ops[i-1], as[i-1], bs[i-1]));
      end
    end
    i_mde_core_model.quiet();
    chk_flag(done, 1'b1);
    chk_res({hi, lo}, expect_of(ops[2], as[2], bs[2]));
    acc = expect_of(ops[2], as[2], bs[2]);
    $display("short multiply stream finished");
  endtask

  task automatic t_wide();
    run_op(OP_MULT, 32'h89ABCDEF, 32'h12345678, WIDE_MUL_CYC, -1);
    run_op(OP_MULTU, 32'hFEDCBA98, 32'h00010000, WIDE_MUL_CYC, -1);
    $display("wide multiply finished");
  endtask

  task automatic t_div();
    run_op(OP_DIVU, 32'hFFFFFFF3, 32'h00000007, DIV_CYC + 1, 5);
    run_op(OP_DIV, 32'h80000007, 32'hFFFFFFFD, DIV_CYC + 1, -1);
    $display("divide finished");
  endtask

  task automatic t_mac();
    i_mde_core_model.send(OP_MTHI, 32'h00000001, 32'h0, 1'b0);
    i_mde_core_model.send(OP_MTLO, 32'hFFFFFFF0, 32'h0, 1'b0);
    i_mde_core_model.quiet();
    @(negedge clock_in);
    acc = 64'h00000001_FFFFFFF0;
    chk_res({hi, lo}, acc);
    for (int i = 0; i < 4; i++) begin
      run_op(4'(OP_MADD + i), 32'hFFFFFF00 + i, 32'h00001000, 1, -1);
    end
    $display("accumulate finished");
  endtask

  // verdict, reached from the main sequence or the watchdog
  task automatic results();
    $display("checks=%0d mismatches=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // watchdog, far beyond the roughly 120 cycles the tests need
  initial begin
    #30000;
    err_count++;
    results();
  end

  // main sequence
  initial begin
    err_count = 0;
    num_checks = 0;
    acc = 64'h0;
    rst_in = 1'b1;
    repeat (20) @(negedge clock_in);
    rst_in = 1'b0;
    chk_flag(busy, 1'b0);
    chk_flag(done, 1'b0);
    chk_res({hi, lo}, 64'h0);
    $display("reset finished");
    t_short();
    t_wide();
    t_div();
    t_mac();
    results();
  end
endmodule
